// ### call_progress_consts.svh
`ifndef CALL_PROGRESS_CONSTS_SVH
`define CALL_PROGRESS_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CTRL_ONE_OFFSET 8'h01
`define CTRL_ONE_RESET 8'h00
`define CTRL_ONE_WMASK 8'hba
`define SELF_RESET_BIT 7
`define FMT_MSB 5
`define FMT_LSB 4
`define PULSE_ENABLE_BIT 3
`define LOOP_BIT 1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_KHZ 250000
`define DS_KHZ 16384
`define SAMPLE_KHZ 16
`define RTZ_KHZ 32
// Bit-clock ticks per monitor period, derived from the rates
`define SAMPLE_TICKS (`DS_KHZ / `SAMPLE_KHZ)
`define RTZ_TICKS (`DS_KHZ / `RTZ_KHZ)

`endif

// ### call_progress_pkg.sv
package call_progress_pkg;

    typedef enum logic [1:0] {
        fmt_delta_sigma = 2'h0,
        fmt_balanced = 2'h1,
        fmt_return_zero = 2'h2,
        fmt_reserved = 2'h3
    } monitor_format_t;

endpackage

// ### sample_fifo.sv
`timescale 1ns/1ns

module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic not_full_reg;
    logic push;
    logic pop;

    // Ready comes from a flop so the top's ready output has no logic
    assign in_ready = not_full_reg;
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            not_full_reg <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                              : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            not_full_reg <= (count_next != (AW+1)'(DEPTH));
        end
    end

endmodule // sample_fifo

// ### call_progress_pwm_control.sv
// Functional notes
// - Writing one to bit 7 returns every register to its reset value.
// - The reset bit clears itself; later reads return zero.
// - With reset bit zero, writes store normally and nothing is disturbed.
// - Bits 5:4 pick the monitor waveform; code 11 is reserved.
// - Code 00 gives a 16.384 MHz delta-sigma stream tracking the sum.
// - Code 01 gives balanced PWM centred on the 16 kHz sample clock.
// - Code 10 falls every 32 kHz period, rises at amplitude-scaled time.
// - With bit 3 clear no PWM data leaves on the monitor output.
// - With bit 3 set, transmit plus receive is driven as CMOS PWM.
// - Bit 1 enables digital loopback across the isolation barrier.
// - Looped data passes through both transmit and receive filters; the monitor takes tx_filtered_sample as receive data instead.
// - Monitor drives the shared pin only while interrupt select is zero.
`include "call_progress_consts.svh"
`timescale 1ns/1ns

module call_progress_pwm_control
    import call_progress_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    output logic soft_reset_pulse,
    output logic barrier_loopback_enable,
    input wire logic audio_valid,
    output logic audio_ready,
    input wire logic [SAMPLE_W-1:0] tx_filtered_sample,
    input wire logic [SAMPLE_W-1:0] rx_filtered_sample,
    input wire logic irq_pin_select,
    output logic monitor_or_irq_pin_o,
    output logic monitor_or_irq_pin_oe
);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic ctrl_hit;
    logic reset_write;

    assign ctrl_hit = (reg_addr == `CTRL_ONE_OFFSET);
    assign reset_write = reg_wr_en && ctrl_hit
                         && reg_wdata[`SELF_RESET_BIT];

    // Reset bit never stays stored, so it always reads back as zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_ONE_RESET;
        end else if (reset_write) begin
            ctrl_reg <= `CTRL_ONE_RESET;
        end else if (reg_wr_en && ctrl_hit) begin
            ctrl_reg <= reg_wdata & `CTRL_ONE_WMASK & 8'h7f;
        end
    end

    // Pulse tells the rest of the register set to reload its defaults
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= reset_write;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= ctrl_hit ? ctrl_reg : 8'h00;
            end
        end
    end

    monitor_format_t fmt;
    logic pwm_enable;
    assign fmt = monitor_format_t'(ctrl_reg[`FMT_MSB:`FMT_LSB]);
    assign pwm_enable = ctrl_reg[`PULSE_ENABLE_BIT];

    // The datapath elsewhere routes line-side transmit back as receive
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            barrier_loopback_enable <= 1'b0;
        end else begin
            barrier_loopback_enable <= ctrl_reg[`LOOP_BIT];
        end
    end

    // ------------------------------------------------------------
    // Bit clock
    // ------------------------------------------------------------
    // Fractional divider; the 16.384 MHz tick jitters by one system
    // clock, which the external filter does not see.
    logic [17:0] phase_reg;
    logic bit_tick_reg;
    logic [9:0] pos_reg;
    logic [18:0] phase_sum;

    assign phase_sum = {1'b0, phase_reg} + 19'(`DS_KHZ);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= '0;
            bit_tick_reg <= 1'b0;
        end else if (phase_sum >= 19'(`CLK_KHZ)) begin
            phase_reg <= 18'(phase_sum - 19'(`CLK_KHZ));
            bit_tick_reg <= 1'b1;
        end else begin
            phase_reg <= phase_sum[17:0];
            bit_tick_reg <= 1'b0;
        end
    end

    // Position inside the 16 kHz sample period, in bit-clock ticks
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos_reg <= '0;
        end else if (bit_tick_reg) begin
            pos_reg <= (pos_reg == 10'(`SAMPLE_TICKS - 1)) ? '0
                       : pos_reg + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // Sample path
    // ------------------------------------------------------------
    logic [SAMPLE_W:0] sum_wide;
    logic [SAMPLE_W-1:0] sum_sat;
    logic [SAMPLE_W-1:0] rx_eff;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [SAMPLE_W-1:0] fifo_out_data;
    logic [SAMPLE_W-1:0] level_reg;

    // In loopback the receive path carries the filtered transmit data
    assign rx_eff = ctrl_reg[`LOOP_BIT] ? tx_filtered_sample
                    : rx_filtered_sample;
    assign sum_wide = {tx_filtered_sample[SAMPLE_W-1], tx_filtered_sample}
                    + {rx_eff[SAMPLE_W-1], rx_eff};

    // Saturate the signed sum, then offset to unsigned level
    always_comb begin
        if (sum_wide[SAMPLE_W] != sum_wide[SAMPLE_W-1]) begin
            sum_sat = {sum_wide[SAMPLE_W],
                       {(SAMPLE_W-1){~sum_wide[SAMPLE_W]}}};
        end else begin
            sum_sat = sum_wide[SAMPLE_W-1:0];
        end
        sum_sat[SAMPLE_W-1] = ~sum_sat[SAMPLE_W-1];
    end

    // One sample is taken per sample period, so the FIFO back-pressures
    assign fifo_pop = bit_tick_reg && (pos_reg == 10'(`SAMPLE_TICKS - 1));

    sample_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(audio_valid),
        .in_ready(audio_ready),
        .in_data(sum_sat),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Underrun holds the previous level rather than jumping to zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            level_reg <= {1'b1, {(SAMPLE_W-1){1'b0}}};
        end else if (fifo_pop && fifo_out_valid) begin
            level_reg <= fifo_out_data;
        end
    end

    // ------------------------------------------------------------
    // Waveform generators
    // ------------------------------------------------------------
    logic [SAMPLE_W:0] ds_sum;
    logic [SAMPLE_W-1:0] ds_acc_reg;
    logic ds_bit_reg;
    logic [9:0] half_w;
    logic bal_bit;
    logic [8:0] rtz_pos;
    logic [8:0] rise_at;
    logic rtz_bit;
    logic wave_bit;

    assign ds_sum = {1'b0, ds_acc_reg} + {1'b0, level_reg};

    // First-order modulator: carry density equals level density
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ds_acc_reg <= '0;
            ds_bit_reg <= 1'b0;
        end else if (bit_tick_reg) begin
            ds_acc_reg <= ds_sum[SAMPLE_W-1:0];
            ds_bit_reg <= ds_sum[SAMPLE_W];
        end
    end

    // High half-width around mid-period keeps both portions centred
    assign half_w = {1'b0, level_reg[SAMPLE_W-1 -: 9]};
    assign bal_bit = (pos_reg >= 10'(`SAMPLE_TICKS / 2) - half_w)
                  && (pos_reg < 10'(`SAMPLE_TICKS / 2) + half_w);

    assign rtz_pos = pos_reg[8:0];
    assign rise_at = level_reg[SAMPLE_W-1 -: 9];
    assign rtz_bit = (rtz_pos != 9'h000) && (rtz_pos >= rise_at);

    always_comb begin
        unique case (fmt)
            fmt_delta_sigma: wave_bit = ds_bit_reg;
            fmt_balanced: wave_bit = bal_bit;
            fmt_return_zero: wave_bit = rtz_bit;
            default: wave_bit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Shared pin
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            monitor_or_irq_pin_o <= 1'b0;
            monitor_or_irq_pin_oe <= 1'b0;
        end else begin
            monitor_or_irq_pin_o <= pwm_enable && wave_bit;
            monitor_or_irq_pin_oe <= !irq_pin_select;
        end
    end

endmodule // call_progress_pwm_control

// ### cp_filter_model.sv
`timescale 1ns/1ns
// ------
// Filter
// ------
module cp_filter_model (
    input wire logic clk_sys,
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic clr,
    output logic [15:0] high_count
);
    // Integrates the pin like the RC filter; a released pin reads low
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            high_count <= 16'h0000;
        end else if (pin_oe && pin_o) begin
            high_count <= high_count + 16'h0001;
        end
    end
endmodule // cp_filter_model

// ### cp_monitor.sv
`timescale 1ns/1ns
// ------
// Checks
// ------
module cp_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic soft_reset_pulse,
    input wire logic barrier_loopback_enable,
    input wire logic irq_pin_select,
    input wire logic monitor_or_irq_pin_o,
    input wire logic monitor_or_irq_pin_oe
);
    logic wr1;
    logic on_reg;
    assign wr1 = reg_wr_en && reg_addr == 8'h01;
    // Mirrors only whether modulation may leave the pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            on_reg <= 1'b0;
        end else if (wr1) begin
            on_reg <= reg_wdata[3] && !reg_wdata[7]
                && reg_wdata[5:4] != 2'h3;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_soft_reset; wr1 && reg_wdata[7] |=> soft_reset_pulse;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("no reset pulse");
    property p_once; soft_reset_pulse |=> !soft_reset_pulse; endproperty
    a_once: assert property (p_once)
        else $error("reset pulse stuck");
    property p_zero; reg_rd_valid |-> (reg_rdata & 8'hc5) == 8'h00;
    endproperty
    a_zero: assert property (p_zero)
        else $error("reserved bit read high");
    property p_calm; wr1 && !reg_wdata[7] |=> !soft_reset_pulse;
    endproperty
    a_calm: assert property (p_calm)
        else $error("spurious reset pulse");
    property p_loop; wr1 && !reg_wdata[7] ##1 !reg_wr_en
        |=> barrier_loopback_enable == $past(reg_wdata[1], 2); endproperty
    a_loop: assert property (p_loop)
        else $error("loopback bit wrong");
    // Four cycles cover the register and the pin's one-clock lag
    property p_quiet; !on_reg [*4] |-> !monitor_or_irq_pin_o; endproperty
    a_quiet: assert property (p_quiet)
        else $error("pin active while off");
    property p_irq; irq_pin_select |=> !monitor_or_irq_pin_oe; endproperty
    a_irq: assert property (p_irq)
        else $error("pin driven in irq use");
    property p_own; !irq_pin_select |=> monitor_or_irq_pin_oe; endproperty
    a_own: assert property (p_own)
        else $error("pin not driven");
endmodule // cp_monitor

// ### testbench.sv
`timescale 1ns/1ns
// -----
// Bench
// -----
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    logic soft_reset_pulse;
    logic barrier_loopback_enable;
    logic audio_valid = 1'b0;
    logic audio_ready;
    logic [15:0] tx_filtered_sample = 16'h2000;
    logic [15:0] rx_filtered_sample = 16'he000;
    logic irq_pin_select = 1'b0;
    logic monitor_or_irq_pin_o;
    logic monitor_or_irq_pin_oe;
    logic clr = 1'b0;
    logic [15:0] high_count;
    int err_count = 0;
    int n_checks = 0;
    always #2 clk_sys = ~clk_sys;
    call_progress_pwm_control u_dut (.clk_sys, .rst_n, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
        .soft_reset_pulse, .barrier_loopback_enable, .audio_valid,
        .audio_ready, .tx_filtered_sample, .rx_filtered_sample,
        .irq_pin_select, .monitor_or_irq_pin_o, .monitor_or_irq_pin_oe);
    cp_filter_model u_filt (.clk_sys, .pin_o(monitor_or_irq_pin_o),
        .pin_oe(monitor_or_irq_pin_oe), .clr, .high_count);
    task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk_sys);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        check("rd_valid", 8'h01, {7'h0, reg_rd_valid});
        check("rdata", exp, reg_rdata);
    endtask
    task automatic push(int n);
        @(negedge clk_sys);
        audio_valid = 1'b1;
        repeat (n) @(negedge clk_sys);
        audio_valid = 1'b0;
    endtask
    // Duty windows span one sample period, or just over one 32 kHz period, so duty settles to the level; the 2000-cycle windows check a quiet pin
    task automatic meas(int n, logic [15:0] lo, logic [15:0] hi);
        @(negedge clk_sys);
        clr = 1'b1;
        @(negedge clk_sys);
        clr = 1'b0;
        repeat (n) @(negedge clk_sys);
        n_checks++;
        if ((high_count >= lo && high_count <= hi) !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED duty exp %h-%h got %h", lo, hi,
                high_count);
        end
    endtask
    task automatic give_verdict;
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        rd(8'h01, 8'h00);
        wr(8'h01, 8'h7f);
        rd(8'h01, 8'h3a);
        wr(8'h02, 8'h08);
        rd(8'h01, 8'h3a);
        rd(8'h02, 8'h00);
        wr(8'h01, 8'hba);
        rd(8'h01, 8'h00);
        wr(8'h01, 8'h0a);
        push(1);
        check("loop", 8'h01, {7'h0, barrier_loopback_enable});
        repeat (16000) @(negedge clk_sys);
        meas(15625, 16'h2b5c, 16'h300c);
        wr(8'h01, 8'h1a);
        meas(15625, 16'h2b5c, 16'h300c);
        wr(8'h01, 8'h2a);
        meas(8000, 16'h06a4, 16'h08fc);
        wr(8'h01, 8'h3a);
        meas(2000, 16'h0000, 16'h0008);
        wr(8'h01, 8'h02);
        meas(2000, 16'h0000, 16'h0008);
        wr(8'h01, 8'h0a);
        irq_pin_select = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("oe", 8'h00, {7'h0, monitor_or_irq_pin_oe});
        irq_pin_select = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("oe", 8'h01, {7'h0, monitor_or_irq_pin_oe});
        push(4);
        check("ready", 8'h00, {7'h0, audio_ready});
        give_verdict();
    end
endmodule // testbench
bind call_progress_pwm_control cp_monitor u_mon (.clk_sys, .rst_n,
    .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .soft_reset_pulse, .barrier_loopback_enable, .irq_pin_select,
    .monitor_or_irq_pin_o, .monitor_or_irq_pin_oe);
